// ===== tmwd_cfg.svh
// Offsets, field positions, reset values and timing counts of the timer,
// watchdog and host-control block. Definitions only; included by name.
`ifndef TMWD_CFG_SVH
`define TMWD_CFG_SVH

// ==========================================================================
// Register offsets (byte offsets from the chip-select base)
`define TMWD_OFS_SYSCTL 6'h00
`define TMWD_OFS_VECTOR 6'h02
`define TMWD_OFS_BWKEY 6'h06
`define TMWD_OFS_TAP 6'h10
`define TMWD_OFS_TMR0 6'h20
`define TMWD_OFS_TMR1 6'h22

// ==========================================================================
// Field positions
`define TMWD_SC_BW 0
`define TMWD_SC_RST 1
`define TMWD_SC_WS_LO 2
`define TMWD_SC_WS_HI 3
`define TMWD_SC_DE 4
`define TMWD_VEC_USER_LO 4
`define TMWD_VEC_USER_HI 7
`define TMWD_TAP_LO 10
`define TMWD_TAP_HI 11
`define TMWD_TMR_EN 8
`define TMWD_TMR_WD 9
`define TMWD_TMR_ST 10

// ==========================================================================
// Reset values and key codes
`define TMWD_SYSCTL_RST 16'h0000
`define TMWD_VEC_RST 4'h0
`define TMWD_BW_KEY_BYTE 8'hFF
`define TMWD_CNT_ZERO 8'h00
`define TMWD_BYTE_ZERO 8'h00

// ==========================================================================
// Divider terminal counts in tap pulses and ticks; reset and wait lengths in reference clock cycles
`define TMWD_PRE_LAST 10'h3FF
`define TMWD_WD_LAST 4'hF
`define TMWD_WDRST_CYC 5'h10
`define TMWD_SRST_CYC 5'h10
`define TMWD_WS_CODE0 3'h0
`define TMWD_WS_CODE1 3'h1
`define TMWD_WS_CODE2 3'h2
`define TMWD_WS_CODE3 3'h4

`endif

// ===== tmwd_host.sv
// Host processor model: register cycles at the device pins.
// Assumes the device clock; pins change on the falling edge.
`timescale 1ns/1ps

module tmwd_host (
    input wire logic clk_i,
    input wire logic ack_n_i,
    input wire tmwd_pkg::tmwd_word_t rd_i,
    output logic cs_n_o = 1'b1,
    output logic iack_n_o = 1'b1,
    output logic rw_o = 1'b1,
    output logic [5:0] addr_o = 6'h00,
    output tmwd_pkg::tmwd_word_t wd_o = 16'h0000
);
    import tmwd_pkg::*;

    // ==========
    // One cycle; a stuck ack yields unknown data
    task automatic acc(input logic ia, input logic rd, input logic [5:0] a,
        input tmwd_word_t w, output tmwd_word_t r);
        int n;
        @(negedge clk_i);
        {rw_o, addr_o, wd_o} = {rd, a, w};
        repeat (3) @(negedge clk_i);
        {cs_n_o, iack_n_o} = {ia, ~ia};
        n = 0;
        do @(posedge clk_i); while (ack_n_i !== 1'b0 && ++n < 20);
        r = (n < 20) ? rd_i : 'x;
        @(negedge clk_i);
        // Released data lines show the inverse, never a stale value; address and direction keep theirs
        {cs_n_o, iack_n_o, wd_o} = {2'h3, ~w};
        n = 0;
        do @(negedge clk_i); while (ack_n_i !== 1'b1 && ++n < 20);
        repeat (3) @(negedge clk_i);
    endtask
endmodule // tmwd_host

// ===== tmwd_pkg.sv
// Types shared by the timer, watchdog and host-control block.
// Assumes the constants of tmwd_cfg.svh for all numeric values.
package tmwd_pkg;

    typedef logic [15:0] tmwd_word_t;

    // Host pins, carried together through the synchroniser
    typedef struct packed {
        logic cs_n;
        logic iack_n;
        logic rw;
        logic uds_n;
        logic lds_n;
        logic [5:0] addr;
        tmwd_word_t data;
        logic d8;
        logic tack_n;
    } tmwd_pins_t;

    // One decoded host access
    typedef struct packed {
        logic wr;
        logic rd;
        logic iack;
        logic [5:0] addr;
        logic [1:0] be;
        tmwd_word_t wdata;
    } tmwd_acc_t;

    typedef enum logic [0:0] {
        TMWD_DMA_IDLE = 1'b0,
        TMWD_DMA_WAIT = 1'b1
    } tmwd_dma_st_t;

endpackage

// ===== tmwd_timer.sv
// One 8-bit down-counting protocol timer with optional divide-by-16 stage.
// Assumes tick_i is a one-cycle enable at the prescaled rate, same clock.
`timescale 1ns/1ps
`include "tmwd_cfg.svh"

module tmwd_timer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic tick_i,
    input wire logic en_i,
    input wire logic wd_en_i,
    input wire logic hold_i,
    input wire logic load_i,
    input wire logic [7:0] load_val_i,
    output logic [7:0] cnt_o,
    output logic uflow_o
);
    import tmwd_pkg::*;

    logic [7:0] cnt_r;
    logic [3:0] pre16_r;
    logic uflow_r;

    // ======================================================================
    // Count-down pulse
    wire last16_w = (pre16_r == `TMWD_WD_LAST);
    wire step_w = tick_i & (~wd_en_i | last16_w);
    // Host access swallows the pulse; accuracy loss is one tick at most
    wire dec_w = step_w & en_i & ~hold_i & ~load_i;
    wire wrap_w = dec_w & (cnt_r == `TMWD_CNT_ZERO);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= `TMWD_CNT_ZERO;
            pre16_r <= 4'h0;
            uflow_r <= 1'b0;
        end
        else if (clr_i)
        begin
            cnt_r <= `TMWD_CNT_ZERO;
            pre16_r <= 4'h0;
            uflow_r <= 1'b0;
        end
        else
        begin
            if (!wd_en_i)
                pre16_r <= 4'h0;
            else if (tick_i)
                pre16_r <= pre16_r + 4'h1;
            if (load_i)
                cnt_r <= load_val_i;
            else if (dec_w)
                cnt_r <= cnt_r - 8'h01;
            uflow_r <= wrap_w;
        end
    end

    assign cnt_o = cnt_r;
    assign uflow_o = uflow_r;

endmodule // tmwd_timer

// ===== tmwd_top.sv
// Timers, watchdog, system control and interrupt vector of the host port.
// Assumes asynchronous host pins; DMA and source inputs on REF_CLK_I.
//
// What this block does
// - Tap output divided by 1024 clocks timers
// - Host reads and loads counter; counts down
// - Wrap 00 to FF raises unmaskable interrupt
// - Counting and wrap interrupt need timer enable
// - Status clears only after read while set, or on soft reset
// - Pulse during host timer access is dropped
// - Watchdog enable adds divide-by-16 to timer 0
// - Watchdog wrap drives reset low 16 cycles
// - Registers at chip-select offsets, byte accessible
// - Writing one to status raises interrupt
// - Control resets zero, upper byte reads zero
// - Bus width flag: 0 narrow, 1 wide
// - FFFF at offset 6 latches wide; D8 low narrow
// - Soft reset bit starts sequence, self-clears
// - Wait field gives 0, 1, 2, 4 states
// - Ack-wait bit also waits for transfer acknowledge
// - Status read returns highest pending source code
// - Acknowledge cycle drives vector byte on bus
// - Source codes: none, serial, timer, channel, faults
// - Channel code: bit0 direction, bit1 channel
// - Upper vector bits are host storage
// - Vector register reads 00 after reset
// - Tap select divides by 2, 4, 8, 16
`timescale 1ns/1ps
`include "tmwd_cfg.svh"

module tmwd_top (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic CS_N_I,
    input wire logic IACK_N_I,
    input wire logic RW_I,
    input wire logic UDS_N_I,
    input wire logic LDS_N_I,
    input wire logic [5:0] ADDR_I,
    input wire tmwd_pkg::tmwd_word_t DATA_I,
    output tmwd_pkg::tmwd_word_t DATA_O,
    output logic DATA_LO_OE_O,
    output logic DATA_HI_OE_O,
    output logic ACK_N_O,
    output logic IRQ_N_O,
    input wire logic UPPER_DATA_BIT8_I,
    output logic RESET_O,
    output logic RESET_OE_O,
    output logic SOFT_RST_O,
    output logic CLK_TAP_EN_O,
    input wire logic SCP_DONE_I,
    input wire logic [3:0] CH_NORM_I,
    input wire logic [3:0] CH_FAULT_I,
    input wire logic [3:0] SYS_FAULT_I,
    input wire logic DMA_START_I,
    input wire logic TRANSFER_ACK_N_I,
    output logic DMA_DONE_O
);
    import tmwd_pkg::*;

    // ======================================================================
    // Pin synchroniser and access detection
    tmwd_pins_t pin_w;
    tmwd_pins_t sync1_r;
    tmwd_pins_t sync2_r;
    tmwd_acc_t acc_w;
    logic sel_d_r;
    logic ack_r;
    logic rdcyc_r;
    logic bw_w;

    assign pin_w = '{cs_n: CS_N_I, iack_n: IACK_N_I, rw: RW_I, uds_n: UDS_N_I, lds_n: LDS_N_I,
                     addr: ADDR_I, data: DATA_I, d8: UPPER_DATA_BIT8_I, tack_n: TRANSFER_ACK_N_I};

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            sync1_r <= '1;
            sync2_r <= '1;
        end
        else
        begin
            sync1_r <= pin_w;
            sync2_r <= sync1_r;
        end
    end

    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        hit = ({a[5:1], 1'b0} == ofs);
    endfunction

    wire cs_w = ~sync2_r.cs_n;
    wire iack_w = ~sync2_r.iack_n;
    wire sel_w = cs_w | iack_w;
    wire start_w = sel_w & ~sel_d_r;
    // Narrow bus: one byte lane picked by the address, data on the low pins
    wire [1:0] be_w = bw_w ? {~sync2_r.uds_n, ~sync2_r.lds_n} : (sync2_r.addr[0] ? 2'b01 : 2'b10);
    wire [15:0] wd_w = bw_w ? sync2_r.data : {sync2_r.data[7:0], sync2_r.data[7:0]};

    assign acc_w.iack = start_w & iack_w;
    assign acc_w.wr = start_w & cs_w & ~iack_w & ~sync2_r.rw;
    assign acc_w.rd = start_w & cs_w & ~iack_w & sync2_r.rw;
    assign acc_w.addr = sync2_r.addr;
    assign acc_w.be = be_w;
    assign acc_w.wdata = wd_w;

    wire wr_lo_w = acc_w.wr & acc_w.be[0];
    wire wr_hi_w = acc_w.wr & acc_w.be[1];

    // ======================================================================
    // Bus width: strap followed every cycle, key latched until hard reset
    logic d8_low_r;
    logic key_hi_r;
    logic key_lo_r;
    logic bw_latch_r;
    wire key_w = wr_hi_w | wr_lo_w;
    wire key_at_w = hit(acc_w.addr, `TMWD_OFS_BWKEY);
    wire key_hi_nxt = (key_w & key_at_w & acc_w.be[1]) ? (wd_w[15:8] == `TMWD_BW_KEY_BYTE) : key_hi_r;
    wire key_lo_nxt = (key_w & key_at_w & acc_w.be[0]) ? (wd_w[7:0] == `TMWD_BW_KEY_BYTE) : key_lo_r;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            d8_low_r <= 1'b1;
            key_hi_r <= 1'b0;
            key_lo_r <= 1'b0;
            bw_latch_r <= 1'b0;
        end
        else
        begin
            d8_low_r <= ~sync2_r.d8;
            key_hi_r <= key_hi_nxt;
            key_lo_r <= key_lo_nxt;
            bw_latch_r <= bw_latch_r | (key_hi_nxt & key_lo_nxt);
        end
    end

    assign bw_w = bw_latch_r & ~d8_low_r;

    // ======================================================================
    // Control registers
    logic [1:0] ws_r;
    logic de_r;
    logic [3:0] user_r;
    logic [1:0] tap_r;
    logic [4:0] srst_r;
    logic [4:0] wdrst_r;
    wire srst_w = (srst_r != 5'h00);
    wire sc_hit_w = hit(acc_w.addr, `TMWD_OFS_SYSCTL);

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ws_r <= 2'b00;
            de_r <= 1'b0;
            user_r <= `TMWD_VEC_RST;
            tap_r <= 2'b00;
            srst_r <= 5'h00;
        end
        else
        begin
            if (wr_lo_w & sc_hit_w)
            begin
                ws_r <= wd_w[`TMWD_SC_WS_HI:`TMWD_SC_WS_LO];
                de_r <= wd_w[`TMWD_SC_DE];
            end
            if (wr_lo_w & sc_hit_w & wd_w[`TMWD_SC_RST])
                srst_r <= `TMWD_SRST_CYC;
            else if (srst_w)
                srst_r <= srst_r - 5'h01;
            if (srst_w)
            begin
                user_r <= `TMWD_VEC_RST;
                tap_r <= 2'b00;
            end
            else
            begin
                if (wr_lo_w & hit(acc_w.addr, `TMWD_OFS_VECTOR))
                    user_r <= wd_w[`TMWD_VEC_USER_HI:`TMWD_VEC_USER_LO];
                if (wr_hi_w & hit(acc_w.addr, `TMWD_OFS_TAP))
                    tap_r <= wd_w[`TMWD_TAP_HI:`TMWD_TAP_LO];
            end
        end
    end

    // ======================================================================
    // Clock tap and divide-by-1024 prescaler
    logic [3:0] tap_cnt_r;
    logic [9:0] pre_r;
    wire [3:0] tap_mask_w = (tap_r == 2'b00) ? 4'h1 : (tap_r == 2'b01) ? 4'h3 : (tap_r == 2'b10) ? 4'h7 : 4'hF;
    wire tap_en_w = ((tap_cnt_r & tap_mask_w) == tap_mask_w);
    wire tick_w = tap_en_w & (pre_r == `TMWD_PRE_LAST);

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            tap_cnt_r <= 4'h0;
            pre_r <= 10'h000;
        end
        else
        begin
            tap_cnt_r <= tap_cnt_r + 4'h1;
            if (tap_en_w)
                pre_r <= pre_r + 10'h001;
        end
    end

    assign CLK_TAP_EN_O = tap_en_w;

    // ======================================================================
    // Timers
    logic [1:0] en_r;
    logic [1:0] wd_r;
    logic [1:0] st_r;
    logic [1:0] arm_r;
    logic [1:0] tuf_w;
    logic [1:0] hold_w;
    logic [7:0] cnt_w [2];
    wire [5:0] tmr_ofs_w [2] = '{`TMWD_OFS_TMR0, `TMWD_OFS_TMR1};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_tmr
            wire at_w = hit(acc_w.addr, tmr_ofs_w[gi]);
            wire ctl_w = wr_hi_w & at_w;
            assign hold_w[gi] = cs_w & ~iack_w & hit(sync2_r.addr, tmr_ofs_w[gi]);
            // Hardware set wins over a clear in the same cycle
            wire st_nxt = tuf_w[gi] | (ctl_w & wd_w[`TMWD_TMR_ST])
                        | (st_r[gi] & ~(ctl_w & ~wd_w[`TMWD_TMR_ST] & arm_r[gi]));

            always_ff @(posedge REF_CLK_I or negedge RST_N_I)
            begin
                if (!RST_N_I)
                begin
                    en_r[gi] <= 1'b0;
                    wd_r[gi] <= 1'b0;
                    st_r[gi] <= 1'b0;
                    arm_r[gi] <= 1'b0;
                end
                else if (srst_w)
                begin
                    en_r[gi] <= 1'b0;
                    wd_r[gi] <= 1'b0;
                    st_r[gi] <= 1'b0;
                    arm_r[gi] <= 1'b0;
                end
                else
                begin
                    if (ctl_w)
                    begin
                        en_r[gi] <= wd_w[`TMWD_TMR_EN];
                        wd_r[gi] <= wd_w[`TMWD_TMR_WD] & (gi == 0);
                    end
                    st_r[gi] <= st_nxt;
                    arm_r[gi] <= st_nxt & (arm_r[gi] | (acc_w.rd & at_w & st_r[gi]));
                end
            end

            tmwd_timer u_tmr (
                .clk_i(REF_CLK_I),
                .rst_n_i(RST_N_I),
                .clr_i(srst_w),
                .tick_i(tick_w),
                .en_i(en_r[gi]),
                .wd_en_i(wd_r[gi]),
                .hold_i(hold_w[gi]),
                .load_i(wr_lo_w & at_w),
                .load_val_i(wd_w[7:0]),
                .cnt_o(cnt_w[gi]),
                .uflow_o(tuf_w[gi])
            );
        end
    endgenerate

    // ======================================================================
    // Watchdog reset pulse and soft reset status
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            wdrst_r <= 5'h00;
        else if (tuf_w[0] & wd_r[0])
            wdrst_r <= `TMWD_WDRST_CYC;
        else if (wdrst_r != 5'h00)
            wdrst_r <= wdrst_r - 5'h01;
    end

    assign RESET_O = 1'b0;
    assign RESET_OE_O = (wdrst_r != 5'h00);
    assign SOFT_RST_O = srst_w;

    // ======================================================================
    // Interrupt source encoding, highest priority first
    function automatic logic [1:0] pick(input logic [3:0] v);
        pick = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
    endfunction

    wire [3:0] code_w = (|SYS_FAULT_I) ? {2'b11, pick(SYS_FAULT_I)}
                      : (|CH_FAULT_I) ? {2'b10, pick(CH_FAULT_I)}
                      : (|CH_NORM_I) ? {2'b01, pick(CH_NORM_I)}
                      : (|st_r) ? {2'b00, ~st_r[0], 1'b1}
                      : SCP_DONE_I ? 4'b0010 : 4'b0000;
    wire [7:0] vec_w = {user_r, code_w};
    assign IRQ_N_O = (code_w == 4'b0000);

    // ======================================================================
    // Read path and bus handshake
    wire [15:0] sc_rd_w = {`TMWD_BYTE_ZERO, 3'b000, de_r, ws_r, srst_w, bw_w};
    wire [15:0] tmr_rd_w [2];
    assign tmr_rd_w[0] = {5'b00000, st_r[0], wd_r[0], en_r[0], cnt_w[0]};
    assign tmr_rd_w[1] = {5'b00000, st_r[1], wd_r[1], en_r[1], cnt_w[1]};
    wire [15:0] rd_w = acc_w.iack ? {`TMWD_BYTE_ZERO, vec_w}
                     : sc_hit_w ? sc_rd_w
                     : hit(acc_w.addr, `TMWD_OFS_VECTOR) ? {`TMWD_BYTE_ZERO, vec_w}
                     : hit(acc_w.addr, `TMWD_OFS_TAP) ? {4'h0, tap_r, 10'h000}
                     : hit(acc_w.addr, `TMWD_OFS_TMR0) ? tmr_rd_w[0]
                     : hit(acc_w.addr, `TMWD_OFS_TMR1) ? tmr_rd_w[1] : 16'h0000;
    wire narrow_lo_w = acc_w.iack | sync2_r.addr[0];
    wire [15:0] lane_w = bw_w ? rd_w : {`TMWD_BYTE_ZERO, narrow_lo_w ? rd_w[7:0] : rd_w[15:8]};

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            sel_d_r <= 1'b0;
            ack_r <= 1'b0;
            rdcyc_r <= 1'b0;
            DATA_O <= 16'h0000;
        end
        else
        begin
            sel_d_r <= sel_w;
            ack_r <= sel_w & (ack_r | start_w);
            rdcyc_r <= sel_w & (start_w ? (acc_w.rd | acc_w.iack) : rdcyc_r);
            if (acc_w.rd | acc_w.iack)
                DATA_O <= lane_w;
        end
    end

    assign ACK_N_O = ~ack_r;
    assign DATA_LO_OE_O = ack_r & rdcyc_r;
    assign DATA_HI_OE_O = ack_r & rdcyc_r & bw_w;

    // ======================================================================
    // DMA wait-state generator
    tmwd_dma_st_t dma_st_r;
    logic [2:0] wcnt_r;
    wire tack_w = ~sync2_r.tack_n;

    function automatic logic [2:0] ws_cycles(input logic [1:0] ws);
        ws_cycles = (ws == 2'b00) ? `TMWD_WS_CODE0 : (ws == 2'b01) ? `TMWD_WS_CODE1
                  : (ws == 2'b10) ? `TMWD_WS_CODE2 : `TMWD_WS_CODE3;
    endfunction

    assign DMA_DONE_O = (dma_st_r == TMWD_DMA_WAIT) & (wcnt_r == 3'h0) & (~de_r | tack_w);

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            dma_st_r <= TMWD_DMA_IDLE;
            wcnt_r <= 3'h0;
        end
        else
        begin
            case (dma_st_r)
                TMWD_DMA_IDLE:
                    if (DMA_START_I)
                    begin
                        dma_st_r <= TMWD_DMA_WAIT;
                        wcnt_r <= ws_cycles(ws_r);
                    end
                TMWD_DMA_WAIT:
                    if (wcnt_r != 3'h0)
                        wcnt_r <= wcnt_r - 3'h1;
                    else if (DMA_DONE_O)
                        dma_st_r <= TMWD_DMA_IDLE;
                default:
                    dma_st_r <= TMWD_DMA_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_wd_len;
        $rose(RESET_OE_O) |-> RESET_OE_O [*8] ##0 (wdrst_r == 5'h09) ##9 !RESET_OE_O;
    endproperty
    a_wd_len: assert property (p_wd_len) else $error("watchdog reset not 16 cycles");
    property p_wd_start;
        tuf_w[0] && wd_r[0] |=> RESET_OE_O;
    endproperty
    a_wd_start: assert property (p_wd_start) else $error("watchdog wrap gave no reset");
    property p_tmr_irq;
        tuf_w[0] |=> st_r[0] && !IRQ_N_O;
    endproperty
    a_tmr_irq: assert property (p_tmr_irq) else $error("timer wrap raised no interrupt");
    property p_en_hold;
        !en_r[0] && !srst_w && !(wr_lo_w && hit(acc_w.addr, `TMWD_OFS_TMR0)) |=> $stable(cnt_w[0]);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("disabled timer counted");
    property p_drop;
        hold_w[1] && !wr_lo_w |=> $stable(cnt_w[1]);
    endproperty
    a_drop: assert property (p_drop) else $error("timer counted during access");
    property p_no_clr;
        st_r[1] && !arm_r[1] && !srst_w |=> st_r[1];
    endproperty
    a_no_clr: assert property (p_no_clr) else $error("status cleared without read");
    property p_srst;
        $rose(srst_w) |-> srst_w [*8] ##9 !srst_w;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset length wrong");
    property p_ws4;
        dma_st_r == TMWD_DMA_IDLE && DMA_START_I && ws_r == 2'b11 && !de_r |=> !DMA_DONE_O [*4] ##1 DMA_DONE_O;
    endproperty
    a_ws4: assert property (p_ws4) else $error("four wait states not kept");
    property p_sc_upper;
        acc_w.rd && sc_hit_w && bw_w |=> DATA_O[15:8] == `TMWD_BYTE_ZERO;
    endproperty
    a_sc_upper: assert property (p_sc_upper) else $error("control upper byte not zero");
    property p_iack_vec;
        acc_w.iack |=> DATA_O[3:0] == $past(code_w);
    endproperty
    a_iack_vec: assert property (p_iack_vec) else $error("vector code wrong");

    c_wd: cover property ($rose(RESET_OE_O));
    c_tmr: cover property (tuf_w[1]);
    c_wide: cover property ($rose(bw_w));
    c_dma_ack: cover property (DMA_DONE_O && de_r);

endmodule // tmwd_top

// ===== tmwd_top_tb.sv
// Self-checking bench of the timer, watchdog and host-control block.
// Assumes tmwd_host as the host; one 200 MHz clock.
`timescale 1ns/1ps

module tmwd_top_tb;
    import tmwd_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, iack_n, rw, ack_n, irq_n, d8, oe_wd, srst, serial_ctrl_port, dstart, tack_n, ddone;
    logic tap, lo_oe, hi_oe, rst_o;
    logic [5:0] addr;
    logic [3:0] chn, chf, sysf;
    tmwd_word_t wd, rdat, r, w;
    int failures = 0;
    int tests_run = 0;
    int oe_cyc = 0;
    int sr_cyc = 0;
    int oe_bad = 0;
    int n;
    integer seed = 32'h1F94;

    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        oe_cyc <= oe_cyc + int'(oe_wd === 1'b1 && rst_o === 1'b0);
        sr_cyc <= sr_cyc + int'(srst === 1'b1);
        // Data drivers only in a read ack phase; upper lane only when wide
        if (rst_n)
            oe_bad <= oe_bad + int'({lo_oe, hi_oe} !== ({2{ack_n === 1'b0 && rw === 1'b1}} & {1'b1, d8}));
    end

    tmwd_top u_dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .IACK_N_I(iack_n), .RW_I(rw),
        .UDS_N_I(1'b0), .LDS_N_I(1'b0), .ADDR_I(addr), .DATA_I(wd), .DATA_O(rdat), .DATA_LO_OE_O(lo_oe),
        .DATA_HI_OE_O(hi_oe), .ACK_N_O(ack_n), .IRQ_N_O(irq_n), .UPPER_DATA_BIT8_I(d8), .RESET_O(rst_o),
        .RESET_OE_O(oe_wd), .SOFT_RST_O(srst), .CLK_TAP_EN_O(tap), .SCP_DONE_I(serial_ctrl_port), .CH_NORM_I(chn),
        .CH_FAULT_I(chf), .SYS_FAULT_I(sysf), .DMA_START_I(dstart), .TRANSFER_ACK_N_I(tack_n),
        .DMA_DONE_O(ddone));
    tmwd_host u_host (.clk_i(clk), .ack_n_i(ack_n), .rd_i(rdat), .cs_n_o(cs_n), .iack_n_o(iack_n),
        .rw_o(rw), .addr_o(addr), .wd_o(wd));

    // ==========
    // Checks and bus helpers
    task automatic chk(input tmwd_word_t got, input tmwd_word_t exp);
        tests_run++;
        if (got !== exp)
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        failures += int'(got !== exp);
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input tmwd_word_t v);
        tmwd_word_t t;
        u_host.acc(1'b0, 1'b0, a, v, t);
    endtask
    task automatic rd(input logic [5:0] a);
        u_host.acc(1'b0, 1'b1, a, 16'h0000, r);
    endtask
    // Later groups outrank earlier ones; low index wins inside a group
    function automatic logic [3:0] code(input logic [11:0] s, input logic sp);
        logic [3:0] c;
        c = sp ? 4'h2 : 4'h0;
        for (int j = 0; j < 12; j++)
            if (s[j / 4 * 4 + 3 - j % 4])
                c = {2'(j / 4 + 1), 2'(3 - j % 4)};
        return c;
    endfunction

    // ==========
    // Main sequence
    initial
    begin
        {d8, serial_ctrl_port, chn, chf, sysf, dstart, tack_n} = 16'h0001;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        // Odd offset: the narrow bus hands over the low byte there
        rd(6'h03);
        chk(r, 16'h0000);
        for (int k = 0; k < 2; k++)
        begin
            d8 = k[0];
            wr(6'h06, 16'hFFFF);
            wr(6'h07, 16'hFFFF);
            rd(6'h01);
            chk(r, 16'(k));
        end
        w = 16'($random(seed)) & 16'hFFFD;
        wr(6'h00, w);
        rd(6'h00);
        chk(r, {11'h000, w[4:2], 2'h1});
        for (int k = 0; k < 8; k++)
        begin
            wr(6'h00, 16'(k << 2));
            dstart = 1'b1;
            n = 0;
            do begin @(negedge clk); dstart = 1'b0; n++; end while (ddone !== 1'b1 && n < 12);
            chk(16'(n), k[2] ? 16'h000C : 16'((k[1:0] == 2'h3 ? 4 : k[1:0]) + 1));
            tack_n = ~k[2];
            n = 0;
            do @(negedge clk); while (k[2] && ddone !== 1'b1 && ++n < 8);
            chk(16'(n < 8), 16'h0001);
            tack_n = 1'b1;
        end
        wr(6'h00, 16'h001E);
        repeat (40) @(negedge clk);
        chk(16'(sr_cyc), 16'h0010);
        rd(6'h00);
        chk(r, 16'h001D);
        for (int i = 0; i < 16; i++)
        begin
            w = 16'($random(seed));
            {sysf, chf, chn, serial_ctrl_port} = w[12:0] & {~{4{i[0]}}, ~{4{i[1]}}, ~{4{i[2]}}, i != 7};
            wr(6'h02, {8'h00, 4'(i), 4'h0});
            rd(6'h02);
            chk(r, {8'h00, 4'(i), code({sysf, chf, chn}, serial_ctrl_port)});
            chk(16'(irq_n), 16'(code({sysf, chf, chn}, serial_ctrl_port) == 4'h0));
            u_host.acc(1'b1, 1'b1, 6'h00, 16'h0000, r);
            chk(r, {8'h00, 4'(i), code({sysf, chf, chn}, serial_ctrl_port)});
        end
        {sysf, chf, chn, serial_ctrl_port} = 13'h0000;
        wr(6'h20, 16'h0005);
        wr(6'h22, 16'h0103);
        repeat (10300) @(negedge clk);
        rd(6'h20);
        chk(r, 16'h0005);
        rd(6'h02);
        chk(r, 16'h00F3);
        wr(6'h22, 16'h0080);
        rd(6'h22);
        chk(r, 16'h0480);
        wr(6'h22, 16'h0080);
        rd(6'h22);
        chk(r, 16'h0080);
        wr(6'h22, 16'h0400);
        rd(6'h22);
        chk(r, 16'h0400);
        wr(6'h20, 16'h0300);
        repeat (34000) @(negedge clk);
        chk(16'(oe_cyc), 16'h0010);
        // Tap rate: 64 cycles hold a whole number of periods for every code
        for (int t = 0; t < 4; t++)
        begin
            wr(6'h10, 16'(t << 10));
            n = 0;
            repeat (64) @(negedge clk) n += int'(tap === 1'b1);
            chk(16'(n), 16'(32 >> t));
        end
        chk(16'(oe_bad), 16'h0000);
        finish_test();
    end

    initial
    begin
        repeat (70000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule // tmwd_top_tb
